// ---- src/nvmpc_defines.vh ----
// What this block does
// - Page select bit picks visible EEPROM page
// - Key enable turns key-range writes into compares
// - Protection loads from nonvolatile byte at reset
// - Protection readable; writes may only grow it
// - Protected target drops command, sets violation
// - Mass erase refused while anything protected
// - EEPROM field sets protected top bytes
// - Open bit clear protects all flash
// - Flash field encodes protected size steps
// - Writing one to buffer-empty launches command
// - Only burst program may be buffered
// - Complete flag: buffer empty and idle
// - Access error on bad sequence, no divider
// - Stop during command raises access error
// - Blank flag set on erased blank check
// - Only six command codes are legal
// - Blank flash check or key unlocks
// - Divided program clock from bus clock
`ifndef NVMPC_DEFINES_VH
`define NVMPC_DEFINES_VH

// Register word offsets
`define NVPC_OFS_CONFIG 8'h00
`define NVPC_OFS_PROT 8'h04
`define NVPC_OFS_STATUS 8'h08
`define NVPC_OFS_CMD 8'h0c
`define NVPC_OFS_DIV 8'h10
`define NVPC_OFS_TARGET 8'h14
`define NVPC_OFS_IRQ_STS 8'h18
`define NVPC_OFS_IRQ_MASK 8'h1c
`define NVPC_OFS_LOCK 8'h20

// Config bits
`define NVPC_CFG_PAGE 6
`define NVPC_CFG_KEY 5

// Status bits
`define NVPC_ST_CBE 7
`define NVPC_ST_CC 6
`define NVPC_ST_PVIOL 5
`define NVPC_ST_ACCERR 4
`define NVPC_ST_BLANK 2

// Divider bits
`define NVPC_DIV_PRE 6
`define NVPC_DIV_MSB 5
`define NVPC_PRE_LAST 3'h7

// Target register: data 31:24, eeprom select 17, address 16:0
`define NVPC_TGT_EE 17
`define NVPC_TGT_DMSB 31
`define NVPC_TGT_DLSB 24

// Interrupt status bits
`define NVPC_IRQ_DONE 0
`define NVPC_IRQ_PVIOL 1
`define NVPC_IRQ_ACCERR 2

// Command codes
`define NVPC_CMD_BLANK 8'h01
`define NVPC_CMD_BYTE 8'h02
`define NVPC_CMD_BURST 8'h03
`define NVPC_CMD_SECT 8'h04
`define NVPC_CMD_MASS 8'h05
`define NVPC_CMD_ABORT 8'h06

// Backdoor key window
`define NVPC_KEY_LO 16'hffb0
`define NVPC_KEY_HI 16'hffb7
`define NVPC_KEY_LAST 3'h7

// Protection encodings
`define NVPC_EE_NONE 2'h3
`define NVPC_FPS_A0 5'h17
`define NVPC_FPS_A1 5'h0f
`define NVPC_FPS_TOP 5'h1f
`define NVPC_UNITS_ARR 7'h20
`define NVPC_UNITS_ALL 7'h40
`define NVPC_UNITS_MID 7'h30
`define NVPC_EE_TOP 15'h4000
`define NVPC_UNLOCKED 2'h2

// Reset values
`define NVPC_RST_STATUS 8'hc0

`endif

// ---- src/nvmpc_prot_decode.v ----
`timescale 1ns/1ps
`include "nvmpc_defines.vh"

// Turns a protection byte into a protected-range test
module nvmpc_prot_decode (
  // Protection setting
  input wire [7:0] i_prot,
  // Target under test
  input wire i_is_eeprom,
  input wire [16:0] i_addr,
  // Results
  output reg o_protected,
  output reg o_any,
  output reg [6:0] o_units,
  output wire [1:0] o_ee_field
);

  wire [1:0] eeprom_protect_field = i_prot[7:6];
  wire [4:0] flash_protect_field = i_prot[5:1];
  wire flash_protect_open = i_prot[0];
  reg [7:0] ee_size; // Protected EEPROM bytes
  reg [6:0] size0; // 2K units in array 0
  reg [6:0] size1; // 2K units in array 1

  assign o_ee_field = eeprom_protect_field;

  // Size decode; flash counted in 2 Kbyte units
  always @* begin
    case (eeprom_protect_field)
      2'h0: ee_size = 8'h80;
      2'h1: ee_size = 8'h40;
      2'h2: ee_size = 8'h20;
      default: ee_size = 8'h00;
    endcase
    if (!flash_protect_open) begin
      o_units = `NVPC_UNITS_ALL;
    end else if (flash_protect_field >= `NVPC_FPS_A0) begin
      o_units = {2'h0, (`NVPC_FPS_TOP - flash_protect_field)} << 2;
    end else if (flash_protect_field >= `NVPC_FPS_A1) begin
      o_units = `NVPC_UNITS_ARR + ({2'h0, (`NVPC_FPS_A0 - flash_protect_field)} << 1);
    end else begin
      o_units = `NVPC_UNITS_MID + {2'h0, (`NVPC_FPS_A1 - flash_protect_field)};
    end
    // Array 0 fills first, then array 1 from its own top
    size0 = (o_units > `NVPC_UNITS_ARR) ? `NVPC_UNITS_ARR : o_units;
    size1 = o_units - size0;
    if (i_is_eeprom) begin
      o_protected = ({1'b0, i_addr[13:0]} + {7'h00, ee_size}) >= `NVPC_EE_TOP;
    end else if (!i_addr[16]) begin
      o_protected = ({2'h0, i_addr[15:11]} + size0) >= `NVPC_UNITS_ARR;
    end else begin
      o_protected = ({2'h0, i_addr[15:11]} + size1) >= `NVPC_UNITS_ARR;
    end
    o_any = (o_units != 7'h00) || (eeprom_protect_field != `NVPC_EE_NONE);
  end

endmodule

// ---- src/nvmpc_top.v ----
`timescale 1ns/1ps
`include "nvmpc_defines.vh"

// Register front end of the flash and EEPROM program/erase controller
module nvmpc_top (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // APB slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  // Nonvolatile values; protection and lock code sampled at reset, key bytes used live
  input wire [7:0] i_nonvolatile_protect_byte,
  input wire [1:0] i_nv_lock_state_code,
  input wire [63:0] i_backdoor_key_bytes,
  // Array engine
  input wire i_op_done,
  input wire i_op_blank,
  input wire i_stop_entry,
  output reg o_op_start,
  output reg [7:0] o_op_code,
  output reg [17:0] o_op_addr,
  output reg [7:0] o_op_data,
  output reg o_nvm_clk_tick,
  // Visible state
  output reg o_eeprom_page_select,
  output reg [1:0] o_lock_state_code,
  output reg o_irq
);

  ////////////////////////////////////////////////////////////////////////
  // Bus decode

  wire setup = i_psel & ~i_penable; // Setup phase
  wire acc = i_psel & i_penable & o_pready; // Completing access
  wire wr = acc & i_pwrite;
  wire rd = acc & ~i_pwrite;
  wire wr_cfg = wr & (i_paddr == `NVPC_OFS_CONFIG);
  wire wr_prot = wr & (i_paddr == `NVPC_OFS_PROT);
  wire wr_st = wr & (i_paddr == `NVPC_OFS_STATUS);
  wire wr_cmd = wr & (i_paddr == `NVPC_OFS_CMD);
  wire wr_div = wr & (i_paddr == `NVPC_OFS_DIV);
  wire wr_tgt = wr & (i_paddr == `NVPC_OFS_TARGET);
  wire wr_msk = wr & (i_paddr == `NVPC_OFS_IRQ_MASK);
  wire rd_irq = rd & (i_paddr == `NVPC_OFS_IRQ_STS);

  ////////////////////////////////////////////////////////////////////////
  // State

  reg key_en_q; // Key compare enable
  reg [7:0] prot_q; // Live protection byte
  reg cbe_q; // Command buffer empty
  reg busy_q; // Array operation running
  reg pviol_q; // Protection violation
  reg accerr_q; // Access error
  reg blank_q; // Array found blank
  reg [7:0] cmd_q; // Staged command code
  reg cmd_ok_q; // Command staged since last launch
  reg tgt_ok_q; // Target staged since last launch
  reg [17:0] tgt_q; // Staged target address
  reg [7:0] tdata_q; // Staged data byte
  reg [6:0] div_q; // Prescale bit and divider
  reg div_set_q; // Divider written since reset
  reg buf_q; // Burst program waiting in buffer
  reg [7:0] run_cmd_q; // Command now on the array
  reg [7:0] key_match_q; // Key bytes matched so far
  reg [2:0] irq_sts_q; // Sticky interrupt events
  reg [2:0] irq_msk_q; // Interrupt enables
  reg [2:0] pre_q; // Divide-by-eight prescaler
  reg [5:0] cnt_q; // Divider counter

  wire [7:0] status = {cbe_q, cbe_q & ~busy_q, pviol_q, accerr_q, 1'b0, blank_q, 2'h0};

  ////////////////////////////////////////////////////////////////////////
  // Protection decode

  wire tgt_prot;
  wire any_prot;
  wire [6:0] units_now;
  wire [1:0] ee_now;
  wire [6:0] units_new;
  wire [1:0] ee_new;

  // Tests the staged target against live protection
  nvmpc_prot_decode u_prot_now (
    .i_prot(prot_q),
    .i_is_eeprom(tgt_q[`NVPC_TGT_EE]),
    .i_addr(tgt_q[16:0]),
    .o_protected(tgt_prot),
    .o_any(any_prot),
    .o_units(units_now),
    .o_ee_field(ee_now)
  );

  // Sizes the value being written, address unused
  nvmpc_prot_decode u_prot_new (
    .i_prot(i_pwdata[7:0]),
    .i_is_eeprom(1'b0),
    .i_addr(17'h00000),
    .o_protected(),
    .o_any(),
    .o_units(units_new),
    .o_ee_field(ee_new)
  );

  // Lower EEPROM field value means a larger region
  wire grows = (ee_new <= ee_now) && (units_new >= units_now);

  ////////////////////////////////////////////////////////////////////////
  // Launch checks

  wire legal = (cmd_q >= `NVPC_CMD_BLANK) && (cmd_q <= `NVPC_CMD_ABORT);
  wire is_burst = cmd_q == `NVPC_CMD_BURST;
  wire is_pe = (cmd_q != `NVPC_CMD_BLANK) && (cmd_q != `NVPC_CMD_ABORT);
  wire launch = wr_st & i_pwdata[`NVPC_ST_CBE];
  // Buffer full, missing stage, or no divider yet
  wire seq_bad = ~cbe_q | ~cmd_ok_q | ~tgt_ok_q | (is_pe & ~div_set_q);
  // Only a burst may queue behind a running burst
  wire busy_bad = busy_q & ~(is_burst & (run_cmd_q == `NVPC_CMD_BURST));
  wire acc_fail = launch & (seq_bad | ~legal | busy_bad);
  wire mass_bad = (cmd_q == `NVPC_CMD_MASS) & any_prot;
  wire prot_bad = is_pe & (cmd_q != `NVPC_CMD_MASS) & tgt_prot;
  wire pv_fail = launch & ~acc_fail & (mass_bad | prot_bad);
  wire accept = launch & ~acc_fail & ~pv_fail;
  wire stop_err = i_stop_entry & busy_q;
  // Array finished; a buffered burst starts at once
  wire finish = busy_q & i_op_done & ~stop_err;
  wire start_now = accept & (~busy_q | finish); // Launch on the finishing edge starts at once
  wire start_buf = finish & buf_q;

  // Key window write to flash; compare enable is applied where it is used
  wire key_hit = wr_tgt & ~i_pwdata[`NVPC_TGT_EE] & ~i_pwdata[16] &
    (i_pwdata[15:0] >= `NVPC_KEY_LO) & (i_pwdata[15:0] <= `NVPC_KEY_HI);
  wire [2:0] key_idx = i_pwdata[2:0];
  wire [7:0] key_byte = i_backdoor_key_bytes[{key_idx, 3'h0} +: 8];
  wire key_good = i_pwdata[`NVPC_TGT_DMSB:`NVPC_TGT_DLSB] == key_byte;

  ////////////////////////////////////////////////////////////////////////
  // Configuration, protection, divider and lock state

  // Protection and lock come from nonvolatile copies at reset
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_eeprom_page_select <= 1'b0;
      key_en_q <= 1'b0;
      prot_q <= i_nonvolatile_protect_byte;
      o_lock_state_code <= i_nv_lock_state_code;
      div_q <= 7'h00;
      div_set_q <= 1'b0;
      irq_msk_q <= 3'h0;
      key_match_q <= 8'h00;
    end else begin
      if (wr_cfg) begin
        o_eeprom_page_select <= i_pwdata[`NVPC_CFG_PAGE];
        key_en_q <= i_pwdata[`NVPC_CFG_KEY];
      end
      if (wr_prot && grows) begin
        prot_q <= i_pwdata[7:0];
      end
      if (wr_div) begin
        div_q <= i_pwdata[6:0];
        div_set_q <= 1'b1;
      end
      if (wr_msk) begin
        irq_msk_q <= i_pwdata[2:0];
      end
      // Eight bytes must match, last at the top of the window
      if (key_hit && key_en_q) begin
        key_match_q[key_idx] <= key_good;
        if (key_idx == `NVPC_KEY_LAST && key_good && (&key_match_q[6:0])) begin
          o_lock_state_code <= `NVPC_UNLOCKED;
        end
      end
      // Blank flash wipes security
      if (finish && run_cmd_q == `NVPC_CMD_BLANK && i_op_blank && !o_op_addr[`NVPC_TGT_EE]) begin
        o_lock_state_code <= `NVPC_UNLOCKED;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command staging

  // A key-window write with compare on is not a command target
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      cmd_q <= 8'h00;
      cmd_ok_q <= 1'b0;
      tgt_ok_q <= 1'b0;
      tgt_q <= 18'h00000;
      tdata_q <= 8'h00;
    end else begin
      if (launch) begin
        cmd_ok_q <= 1'b0;
        tgt_ok_q <= 1'b0;
      end
      if (wr_cmd) begin
        cmd_q <= i_pwdata[7:0];
        cmd_ok_q <= 1'b1;
      end
      if (wr_tgt && !(key_hit && key_en_q)) begin
        tgt_q <= i_pwdata[17:0];
        tdata_q <= i_pwdata[`NVPC_TGT_DMSB:`NVPC_TGT_DLSB];
        tgt_ok_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status flags and array hand-off

  // Hardware sets win over software clears
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      {cbe_q, busy_q} <= 2'h2;
      pviol_q <= 1'b0;
      accerr_q <= 1'b0;
      blank_q <= 1'b0;
      buf_q <= 1'b0;
      run_cmd_q <= 8'h00;
      o_op_start <= 1'b0;
      o_op_code <= 8'h00;
      o_op_addr <= 18'h00000;
      o_op_data <= 8'h00;
    end else begin
      o_op_start <= start_now | start_buf;
      // Write-one clears
      if (wr_st && i_pwdata[`NVPC_ST_PVIOL]) begin
        pviol_q <= 1'b0;
      end
      if (wr_st && i_pwdata[`NVPC_ST_ACCERR]) begin
        accerr_q <= 1'b0;
      end
      if (pv_fail) begin
        pviol_q <= 1'b1;
      end
      if (acc_fail || stop_err) begin
        accerr_q <= 1'b1;
      end
      // Direct start; buffer stays empty
      if (start_now) begin
        busy_q <= 1'b1;
        blank_q <= 1'b0;
        run_cmd_q <= cmd_q;
        o_op_code <= cmd_q;
        o_op_addr <= tgt_q;
        o_op_data <= tdata_q;
      end
      // Burst queued while array busy; empty flag drops
      if (accept && busy_q && !finish) begin
        buf_q <= 1'b1;
        cbe_q <= 1'b0;
        blank_q <= 1'b0;
        o_op_addr <= tgt_q;
        o_op_data <= tdata_q;
      end
      if (finish) begin
        if (run_cmd_q == `NVPC_CMD_BLANK) begin
          blank_q <= i_op_blank;
        end
        // Buffered burst moves to the array
        if (buf_q) begin
          buf_q <= 1'b0;
          cbe_q <= 1'b1;
        end else if (!start_now) begin
          busy_q <= 1'b0;
        end
      end
      // Stop aborts everything
      if (stop_err) begin
        busy_q <= 1'b0;
        buf_q <= 1'b0;
        cbe_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Program/erase clock

  // One-cycle tick per divided period; counts from reset
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      pre_q <= 3'h0;
      cnt_q <= 6'h00;
      o_nvm_clk_tick <= 1'b0;
    end else begin
      o_nvm_clk_tick <= 1'b0;
      if (!div_q[`NVPC_DIV_PRE] || pre_q == `NVPC_PRE_LAST) begin
        pre_q <= 3'h0;
        if (cnt_q >= div_q[`NVPC_DIV_MSB:0]) begin
          cnt_q <= 6'h00;
          o_nvm_clk_tick <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 6'h01;
        end
      end else begin
        pre_q <= pre_q + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupts

  wire [2:0] ev = {acc_fail | stop_err, pv_fail, finish & ~buf_q};
  // Read clears only what the read returned
  wire [2:0] irq_clr = rd_irq ? o_prdata[2:0] : 3'h0;
  wire [2:0] irq_d = (irq_sts_q & ~irq_clr) | ev;

  // Set wins over the read clear
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      irq_sts_q <= 3'h0;
      o_irq <= 1'b0;
    end else begin
      irq_sts_q <= irq_d;
      o_irq <= |(irq_d & (wr_msk ? i_pwdata[2:0] : irq_msk_q));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read mux and ready

  reg [31:0] rdata_d; // Read data for the setup address
  reg err_d; // Unmapped address

  // Read value captured in setup, shown in access
  always @* begin
    rdata_d = 32'h00000000;
    err_d = 1'b0;
    case (i_paddr)
      `NVPC_OFS_CONFIG: rdata_d[7:0] = {1'b0, o_eeprom_page_select, key_en_q, 5'h00};
      `NVPC_OFS_PROT: rdata_d[7:0] = prot_q;
      `NVPC_OFS_STATUS: rdata_d[7:0] = status;
      `NVPC_OFS_CMD: rdata_d[7:0] = cmd_q;
      `NVPC_OFS_DIV: rdata_d[6:0] = div_q;
      `NVPC_OFS_TARGET: rdata_d = {tdata_q, 6'h00, tgt_q};
      `NVPC_OFS_IRQ_STS: rdata_d[2:0] = irq_sts_q;
      `NVPC_OFS_IRQ_MASK: rdata_d[2:0] = irq_msk_q;
      `NVPC_OFS_LOCK: rdata_d[1:0] = o_lock_state_code;
      default: err_d = 1'b1;
    endcase
  end

  // Fixed one access cycle: ready follows every setup
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_prdata <= 32'h00000000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= setup;
      if (setup) begin
        o_prdata <= i_pwrite ? 32'h00000000 : rdata_d;
        o_pslverr <= err_d;
      end else begin
        o_pslverr <= 1'b0;
      end
    end
  end

endmodule

// ---- testbench/nvmpc_top_props.sv ----
`timescale 1ns/1ps
`include "nvmpc_defines.vh"

// Port-level properties of the controller front end
module nvmpc_top_props (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // APB slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [31:0] o_prdata,
  input wire o_pready,
  input wire o_pslverr,
  // Array engine
  input wire i_op_done,
  input wire o_op_start,
  input wire [7:0] o_op_code,
  // Visible state
  input wire o_eeprom_page_select,
  input wire [1:0] o_lock_state_code
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  ////////////////////////////////////////////////////////////////
  // Completed transfers, as the slave sees them
  wire acc = i_psel && i_penable && o_pready;
  wire cfg_wr = acc && i_pwrite && i_paddr == `NVPC_OFS_CONFIG;
  wire launch = acc && i_pwrite && i_paddr == `NVPC_OFS_STATUS && i_pwdata[7];

  ////////////////////////////////////////////////////////////////
  // Zero wait states, one-cycle answers
  property p_ready_next; i_psel && !i_penable |=> o_pready; endproperty
  a_ready_next: assert property (p_ready_next) else $error("pready late after setup");
  property p_ready_pulse; o_pready |=> !o_pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held too long");
  property p_err_ready; o_pslverr |-> o_pready; endproperty
  a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
  property p_wr_zero; o_pready && i_pwrite |-> o_prdata == 32'h0; endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("read data nonzero on write");

  ////////////////////////////////////////////////////////////////
  // Page select follows config writes only
  property p_page; cfg_wr |-> ##[1:2] o_eeprom_page_select == $past(i_pwdata[6], 1); endproperty
  a_page: assert property (p_page) else $error("page select missed write");
  property p_page_cause;
    $changed(o_eeprom_page_select) |-> $past(cfg_wr) || $past(cfg_wr, 2);
  endproperty
  a_page_cause: assert property (p_page_cause) else $error("page select moved alone");

  ////////////////////////////////////////////////////////////////
  // Lock code may only move to unsecured
  property p_lock; $changed(o_lock_state_code) |-> o_lock_state_code == 2'h2; endproperty
  a_lock: assert property (p_lock) else $error("lock code moved wrongly");

  ////////////////////////////////////////////////////////////////
  // Starts come from a launch or a buffered burst
  property p_start_cause; o_op_start |-> $past(launch) || $past(i_op_done); endproperty
  a_start_cause: assert property (p_start_cause) else $error("start without cause");
  property p_start_pulse; o_op_start |=> !o_op_start; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
  property p_code_legal; o_op_start |-> o_op_code >= 8'h01 && o_op_code <= 8'h06; endproperty
  a_code_legal: assert property (p_code_legal) else $error("illegal code started");
endmodule

bind nvmpc_top nvmpc_top_props u_props (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_op_done(i_op_done),
  .o_op_start(o_op_start), .o_op_code(o_op_code),
  .o_eeprom_page_select(o_eeprom_page_select), .o_lock_state_code(o_lock_state_code));

// ---- testbench/nvmpc_top_tb.sv ----
`timescale 1ns/1ps
`include "nvmpc_defines.vh"

// Compare one value, count and report
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end

module nvmpc_top_tb;
  // Stimulus, all given a value at time zero
  logic i_clk = 0, i_rst_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic i_op_done = 0, i_op_blank = 0, i_stop_entry = 0;
  logic [7:0] i_paddr = 0, i_nonvolatile_protect_byte = 8'hff;
  logic [31:0] i_pwdata = 0;
  logic [1:0] i_nv_lock_state_code = 2'h0;
  logic [63:0] i_backdoor_key_bytes = 64'h0;
  // Observed outputs
  wire [31:0] o_prdata;
  wire o_pready, o_pslverr, o_op_start, o_nvm_clk_tick, o_eeprom_page_select, o_irq;
  wire [7:0] o_op_code, o_op_data;
  wire [17:0] o_op_addr;
  wire [1:0] o_lock_state_code;
  // Bookkeeping; reads note {pslverr, data} before they start
  int bad_count = 0, checks_done = 0, g;
  logic [32:0] exp_q[$];
  logic [32:0] exp_v;
  logic [7:0] rnd = 8'h0;
  logic [17:0] tg[4] = '{18'h23fff, 18'h0ffff, 18'h0dfff, 18'h23f00};
  logic [7:0] bad_codes[3] = '{8'h00, 8'h07, 8'hff};

  initial forever #2.5 i_clk = ~i_clk;

  nvmpc_top DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_nonvolatile_protect_byte(i_nonvolatile_protect_byte),
    .i_nv_lock_state_code(i_nv_lock_state_code), .i_backdoor_key_bytes(i_backdoor_key_bytes),
    .i_op_done(i_op_done), .i_op_blank(i_op_blank), .i_stop_entry(i_stop_entry),
    .o_op_start(o_op_start), .o_op_code(o_op_code), .o_op_addr(o_op_addr),
    .o_op_data(o_op_data), .o_nvm_clk_tick(o_nvm_clk_tick),
    .o_eeprom_page_select(o_eeprom_page_select), .o_lock_state_code(o_lock_state_code),
    .o_irq(o_irq));

  ////////////////////////////////////////////////////////////////
  // One APB transfer; request held until pready is seen high
  task apb(input bit w, input [7:0] a, input [31:0] d);
    int n;
    @(posedge i_clk);
    i_psel <= 1; i_penable <= 0; i_pwrite <= w; i_paddr <= a; i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1;
    n = 0;
    do begin @(posedge i_clk); n++; end while (o_pready !== 1'b1 && n < 20);
    if (n >= 20) bad_count++;
    i_psel <= 0; i_penable <= 0;
  endtask
  task wr(input [7:0] a, input [31:0] d); apb(1, a, d); endtask
  task rd(input [7:0] a, input [31:0] e, input bit err = 0);
    exp_q.push_back({err, e});
    apb(0, a, 32'h0);
  endtask
  // Command, target with random data byte, then launch
  task launch(input [7:0] c, input [17:0] t);
    rnd = $urandom;
    wr(`NVPC_OFS_CMD, {24'h0, c});
    wr(`NVPC_OFS_TARGET, {rnd, 6'h0, t});
    wr(`NVPC_OFS_STATUS, 32'h80);
  endtask
  // Bounded wait for a start pulse, then check what it carries
  task start_seen(input [7:0] c, input [17:0] t);
    int n;
    n = 0;
    do begin @(posedge i_clk); n++; end while (o_op_start !== 1'b1 && n < 20);
    `CHK("op start", 1'b1, o_op_start)
    `CHK("op code", c, o_op_code)
    `CHK("op addr", t, o_op_addr)
    `CHK("op data", rnd, o_op_data)
  endtask
  // Array engine finishing one operation
  task done(input bit b);
    i_op_blank <= b; i_op_done <= 1;
    @(posedge i_clk);
    i_op_done <= 0;
  endtask
  // Cycles between two program clock ticks
  task gap(output int k);
    int n;
    n = 0;
    do @(posedge i_clk); while (o_nvm_clk_tick !== 1'b1 && n++ < 200);
    k = 0;
    do begin @(posedge i_clk); k++; end while (o_nvm_clk_tick !== 1'b1 && k < 200);
  endtask

  ////////////////////////////////////////////////////////////////
  // Read results are paired with the oldest note
  always @(posedge i_clk)
    if (i_psel && i_penable && o_pready === 1'b1 && !i_pwrite && exp_q.size() > 0) begin
      exp_v = exp_q.pop_front();
      `CHK("read data", exp_v, {o_pslverr, o_prdata})
    end

  task report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles needed
  initial begin
    #100000;
    bad_count++;
    report_and_stop;
  end

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(32'hc39fba2e));
    i_backdoor_key_bytes <= {$urandom, $urandom};
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1;
    rd(`NVPC_OFS_STATUS, 32'hc0);
    rd(`NVPC_OFS_PROT, 32'hff);
    rd(8'h24, 32'h0, 1);
    wr(`NVPC_OFS_CONFIG, 32'h40);
    rd(`NVPC_OFS_CONFIG, 32'h40);
    `CHK("page select", 1'b1, o_eeprom_page_select)
    wr(`NVPC_OFS_IRQ_MASK, 32'h1);
    // Program before divider set, zero write, then clear
    launch(`NVPC_CMD_BYTE, 18'h0);
    wr(`NVPC_OFS_STATUS, 32'h0);
    rd(`NVPC_OFS_STATUS, 32'hd0);
    wr(`NVPC_OFS_STATUS, 32'h10);
    rd(`NVPC_OFS_STATUS, 32'hc0);
    foreach (bad_codes[i]) begin
      launch(bad_codes[i], 18'h0);
      rd(`NVPC_OFS_STATUS, 32'hd0);
      wr(`NVPC_OFS_STATUS, 32'h10);
    end
    `CHK("irq masked", 1'b0, o_irq)
    rd(`NVPC_OFS_IRQ_STS, 32'h4);
    // Divider, plain and prescaled
    wr(`NVPC_OFS_DIV, 32'h03);
    gap(g);
    `CHK("tick gap", 4, g)
    wr(`NVPC_OFS_DIV, 32'h41);
    gap(g);
    gap(g);
    `CHK("tick gap", 16, g)
    // Protection may grow but never shrink
    wr(`NVPC_OFS_PROT, 32'hbd);
    rd(`NVPC_OFS_PROT, 32'hbd);
    wr(`NVPC_OFS_PROT, 32'hff);
    wr(`NVPC_OFS_PROT, 32'hbf);
    rd(`NVPC_OFS_PROT, 32'hbd);
    // Protected and free targets in EEPROM and flash array 0
    foreach (tg[i]) begin
      launch(`NVPC_CMD_BYTE, tg[i]);
      if (i < 2) begin
        rd(`NVPC_OFS_STATUS, 32'he0);
        wr(`NVPC_OFS_STATUS, 32'h20);
      end else begin
        start_seen(`NVPC_CMD_BYTE, tg[i]);
        rd(`NVPC_OFS_STATUS, 32'h80);
        done(0);
        rd(`NVPC_OFS_STATUS, 32'hc0);
      end
    end
    launch(`NVPC_CMD_MASS, 18'h0);
    rd(`NVPC_OFS_STATUS, 32'he0);
    wr(`NVPC_OFS_STATUS, 32'h20);
    `CHK("irq up", 1'b1, o_irq)
    rd(`NVPC_OFS_IRQ_STS, 32'h3);
    repeat (2) @(posedge i_clk);
    `CHK("irq down", 1'b0, o_irq)
    // Stop while busy
    launch(`NVPC_CMD_BYTE, 18'h0);
    start_seen(`NVPC_CMD_BYTE, 18'h0);
    i_stop_entry <= 1;
    @(posedge i_clk);
    i_stop_entry <= 0;
    rd(`NVPC_OFS_STATUS, 32'hd0);
    wr(`NVPC_OFS_STATUS, 32'h10);
    // Blank check, erased then not
    launch(`NVPC_CMD_BLANK, 18'h0);
    start_seen(`NVPC_CMD_BLANK, 18'h0);
    done(1);
    rd(`NVPC_OFS_STATUS, 32'hc4);
    rd(`NVPC_OFS_LOCK, 32'h2);
    launch(`NVPC_CMD_BLANK, 18'h0);
    start_seen(`NVPC_CMD_BLANK, 18'h0);
    done(0);
    rd(`NVPC_OFS_STATUS, 32'hc0);
    // Burst buffered behind a burst, then a launch while full
    launch(`NVPC_CMD_BURST, 18'h0);
    start_seen(`NVPC_CMD_BURST, 18'h0);
    launch(`NVPC_CMD_BURST, 18'h1);
    rd(`NVPC_OFS_STATUS, 32'h00);
    wr(`NVPC_OFS_STATUS, 32'h80);
    rd(`NVPC_OFS_STATUS, 32'h10);
    done(0);
    start_seen(`NVPC_CMD_BURST, 18'h1);
    rd(`NVPC_OFS_STATUS, 32'h90);
    done(0);
    rd(`NVPC_OFS_STATUS, 32'hd0);
    // Mid-run reset reloads protection and lock code
    i_nonvolatile_protect_byte <= 8'h3e;
    i_rst_n <= 0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1;
    rd(`NVPC_OFS_PROT, 32'h3e);
    rd(`NVPC_OFS_LOCK, 32'h0);
    // Open bit clear guards all flash; widest EEPROM field
    wr(`NVPC_OFS_DIV, 32'h03);
    launch(`NVPC_CMD_BYTE, 18'h00000);
    rd(`NVPC_OFS_STATUS, 32'he0);
    wr(`NVPC_OFS_STATUS, 32'h20);
    launch(`NVPC_CMD_BYTE, 18'h23f80);
    rd(`NVPC_OFS_STATUS, 32'he0);
    // Key range stages a target until key compare is on
    wr(`NVPC_OFS_TARGET, 32'h5a00ffb0);
    rd(`NVPC_OFS_TARGET, 32'h5a00ffb0);
    wr(`NVPC_OFS_CONFIG, 32'h20);
    // Last byte alone first, then all eight in order
    for (int n = 0; n < 9; n++) begin
      g = (n + 7) % 8;
      wr(`NVPC_OFS_TARGET, {i_backdoor_key_bytes[8*g +: 8], 6'h0, 18'h0ffb0 | 18'(g)});
      if (n == 0) rd(`NVPC_OFS_LOCK, 32'h0);
    end
    rd(`NVPC_OFS_LOCK, 32'h2);
    rd(`NVPC_OFS_TARGET, 32'h5a00ffb0);
    repeat (4) @(posedge i_clk);
    report_and_stop;
  end
endmodule
